// ### design/kbu_keyboard_unit.sv
// Operation
// - Each enable bit selects one pin
// - Selected pin gets its pull-up
// - Latch when selected pins leave all-high
// - Edge mode: no latch if another low
// - Level mode: request held while any low
// - Level mode: clear needs ack and pins high
// - Vector fetch acknowledges request
// - Acknowledge bit write-only, reads zero
// - Later falling edge latches again
// - Unmasked request goes to CPU vector
// - Edge mode: acknowledge clears at once
// - Reset clears request and mode bit
// - Pending flag mirrors latch, ignores mask
// - Enabled pin forced to input
// - Mask bit blocks request to CPU
// - Mode bit: one edge+level, zero edge
// - Reset clears all pin enables
// - Active in wait, wakes CPU
// - Active in stop, wakes CPU
// - Break without clear-enable ignores ack bit write
// - Break with clear-enable ack sticks
`timescale 1ns/1ps
`default_nettype none

module kbu_keyboard_unit #(
  parameter int PINS = 8
) (
  input  wire logic                  clock_in,
  input  wire logic                  resetn_in,
  // Register port
  input  wire kbu_pkg::kbu_bus_req_t bus_in,
  output logic [7:0]                 rdata_out,
  // System signals
  input  wire kbu_pkg::kbu_sys_t     sys_in,
  // Shared port pins
  input  wire logic [PINS-1:0]       key_inputs_in,
  input  wire logic [PINS-1:0]       port_dir_in,
  output logic [PINS-1:0]            pullup_en_out,
  output logic [PINS-1:0]            dir_force_in_out,
  output logic [PINS-1:0]            port_dir_eff_out,
  // CPU side
  output logic                       irq_out,
  output logic                       wake_out,
  output logic                       pending_out
);

  // ==========================================================================
  // Registers
  logic [PINS-1:0]     key_pin_enable_bits_r;
  logic                sensitivity_select_r;
  logic                request_mask_r;
  logic                latch_r;
  logic                any_low_r;
  kbu_pkg::kbu_state_t state_r;
  kbu_pkg::kbu_state_t state_nxt;

  logic [PINS-1:0] pin_lvl;
  logic [PINS-1:0] masked_lvl;
  logic            any_low;
  logic            fall;
  logic            ack_wr;
  logic            ack;
  logic            wr_ctrl;
  logic            wr_en;
  logic            set_latch;
  logic            latch_nxt;

  // ==========================================================================
  // Pin synchronisation
  // sync before detect
  kbu_pin_sync #(
    .WIDTH (PINS)
  ) u_sync (
    .clock_in  (clock_in),
    .resetn_in (resetn_in),
    .async_in  (key_inputs_in),
    .level_out (pin_lvl)
  );

  // ==========================================================================
  // Per-pin logic
  genvar p;
  generate
    for (p = 0; p < PINS; p++) begin : g_pin
      assign masked_lvl[p] = pin_lvl[p] | ~key_pin_enable_bits_r[p];

      // Pad controls follow the select one clock late
      always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
          pullup_en_out[p]    <= 1'b0;
          dir_force_in_out[p] <= 1'b0;
          port_dir_eff_out[p] <= 1'b0;
        end else begin
          pullup_en_out[p]    <= key_pin_enable_bits_r[p];
          dir_force_in_out[p] <= key_pin_enable_bits_r[p];
          port_dir_eff_out[p] <= port_dir_in[p] & ~key_pin_enable_bits_r[p];
        end
      end
    end
  endgenerate

  assign any_low = ~&masked_lvl;

  assign fall = any_low & ~any_low_r;

  // ==========================================================================
  // Register writes
  assign wr_ctrl = bus_in.wr && (bus_in.addr == kbu_pkg::KEY_STATUS_CONTROL_OFFS);
  assign wr_en   = bus_in.wr && (bus_in.addr == kbu_pkg::KEY_PIN_ENABLE_BITS_OFFS);
  assign ack_wr  = wr_ctrl && bus_in.wdata[kbu_pkg::REQUEST_ACKNOWLEDGE_BIT]
                   && (!sys_in.break_state || sys_in.break_clear_enable);
  assign ack     = ack_wr | sys_in.vector_fetch;

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      key_pin_enable_bits_r <= kbu_pkg::PIN_ENABLE_RESET;
    end else if (wr_en) begin
      key_pin_enable_bits_r <= bus_in.wdata[PINS-1:0];
    end
  end

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sensitivity_select_r <= kbu_pkg::CTRL_BIT_RESET;
      request_mask_r       <= kbu_pkg::CTRL_BIT_RESET;
    end else if (wr_ctrl) begin
      sensitivity_select_r <= bus_in.wdata[kbu_pkg::SENSITIVITY_SELECT_BIT];
      request_mask_r       <= bus_in.wdata[kbu_pkg::REQUEST_MASK_BIT];
    end
  end

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      any_low_r <= 1'b0;
    end else begin
      any_low_r <= any_low;
    end
  end

  // ==========================================================================
  // Request latch
  // a fresh edge in the same cycle as ack wins
  assign set_latch = fall;

  always_comb begin
    state_nxt = state_r;
    latch_nxt = latch_r;
    case (state_r)
      kbu_pkg::KBU_IDLE: begin
        if (set_latch) begin
          state_nxt = kbu_pkg::KBU_PENDING;
          latch_nxt = 1'b1;
        end
      end
      kbu_pkg::KBU_PENDING: begin
        if (set_latch) begin
          latch_nxt = 1'b1;
        end else if (ack && !sensitivity_select_r) begin
          state_nxt = kbu_pkg::KBU_IDLE;
          latch_nxt = 1'b0;
        // level mode waits for pins high
        end else if (ack && any_low) begin
          state_nxt = kbu_pkg::KBU_HOLD;
        end else if (ack) begin
          state_nxt = kbu_pkg::KBU_IDLE;
          latch_nxt = 1'b0;
        end
      end
      kbu_pkg::KBU_HOLD: begin
        if (!sensitivity_select_r || !any_low) begin
          state_nxt = kbu_pkg::KBU_IDLE;
          latch_nxt = 1'b0;
        end
      end
      default: begin
        state_nxt = kbu_pkg::KBU_IDLE;
        latch_nxt = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_r <= kbu_pkg::KBU_IDLE;
      latch_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      latch_r <= latch_nxt;
    end
  end

  // ==========================================================================
  // Outputs, all registered
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      irq_out          <= 1'b0;
      wake_out         <= 1'b0;
      pending_out      <= 1'b0;
    end else begin
      irq_out          <= latch_nxt & ~request_mask_r;
      wake_out         <= latch_nxt & ~request_mask_r
                          & (sys_in.wait_mode | sys_in.stop_mode);
      pending_out      <= latch_nxt;
    end
  end

  // ==========================================================================
  // Read port
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rdata_out <= 8'h00;
    end else if (bus_in.rd) begin
      rdata_out <= 8'h00;
      if (bus_in.addr == kbu_pkg::KEY_STATUS_CONTROL_OFFS) begin
        rdata_out[kbu_pkg::PENDING_FLAG_BIT]       <= latch_r;
        rdata_out[kbu_pkg::REQUEST_ACKNOWLEDGE_BIT] <= 1'b0;
        rdata_out[kbu_pkg::REQUEST_MASK_BIT]       <= request_mask_r;
        rdata_out[kbu_pkg::SENSITIVITY_SELECT_BIT] <= sensitivity_select_r;
      end else if (bus_in.addr == kbu_pkg::KEY_PIN_ENABLE_BITS_OFFS) begin
        rdata_out[PINS-1:0] <= key_pin_enable_bits_r;
      end
    end else begin
      rdata_out <= 8'h00;
    end
  end

endmodule : kbu_keyboard_unit

`default_nettype wire

// ### design/kbu_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none

// ============================================================================
// Pin synchroniser: three stages, a change counts when stages two and three agree
module kbu_pin_sync #(
  parameter int WIDTH = 8
) (
  input  wire logic             clock_in,
  input  wire logic             resetn_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] level_out
);

  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      logic s1_r;
      logic s2_r;
      logic s3_r;
      logic lvl_r;
      // Idle high: pins pulled up, so no false edge out of reset
      always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
          s1_r  <= 1'b1;
          s2_r  <= 1'b1;
          s3_r  <= 1'b1;
          lvl_r <= 1'b1;
        end else begin
          s1_r <= async_in[g];
          s2_r <= s1_r;
          s3_r <= s2_r;
          if (s2_r == s3_r) begin
            lvl_r <= s3_r;
          end
        end
      end
      assign level_out[g] = lvl_r;
    end
  endgenerate

endmodule : kbu_pin_sync

`default_nettype wire

// ### design/kbu_pkg.sv
package kbu_pkg;

  // ==========================================================================
  // Register map
  localparam logic [7:0] KEY_STATUS_CONTROL_OFFS  = 8'h1A;
  localparam logic [7:0] KEY_PIN_ENABLE_BITS_OFFS = 8'h1B;

  // Status/control field positions
  localparam int PENDING_FLAG_BIT        = 3;
  localparam int REQUEST_ACKNOWLEDGE_BIT = 2;
  localparam int REQUEST_MASK_BIT        = 1;
  localparam int SENSITIVITY_SELECT_BIT  = 0;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] PIN_ENABLE_RESET = 8'h00;
  localparam logic       CTRL_BIT_RESET   = 1'b0;
  localparam logic [7:0] PINS_HIGH        = 8'hFF;

  // Synchroniser depth for pin inputs
  localparam int SYNC_STAGES = 3;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } kbu_bus_req_t;

  typedef struct packed {
    logic wait_mode;
    logic stop_mode;
    logic break_state;
    logic break_clear_enable;
    logic vector_fetch;
  } kbu_sys_t;

  typedef enum logic [2:0] {
    KBU_IDLE    = 3'b001,
    KBU_PENDING = 3'b010,
    KBU_HOLD    = 3'b100
  } kbu_state_t;

endpackage : kbu_pkg

// ### test/kbu_key_model.sv
`timescale 1ns/1ps
`default_nettype none

module kbu_key_model (
  input  wire logic       clock_in,
  input  wire logic [7:0] press_in,
  input  wire logic [7:0] pullup_in,
  output logic      [7:0] pins_out
);
  logic float_r = 1'b0;
  // Unpulled idle lines wander so a stale level never passes as valid
  always @(posedge clock_in) float_r <= !float_r;
  assign pins_out = ~press_in & (pullup_in | {8{float_r}});
endmodule : kbu_key_model

`default_nettype wire

// ### test/kbu_keyboard_unit_sva.sv
`timescale 1ns/1ps
`default_nettype none

module kbu_keyboard_unit_sva #(
  parameter int PINS = 8
) (
  input wire logic                  clock_in,
  input wire logic                  resetn_in,
  input wire kbu_pkg::kbu_bus_req_t bus_in,
  input wire logic [7:0]            rdata_out,
  input wire kbu_pkg::kbu_sys_t     sys_in,
  input wire logic [PINS-1:0]       key_inputs_in,
  input wire logic [PINS-1:0]       port_dir_in,
  input wire logic [PINS-1:0]       pullup_en_out,
  input wire logic [PINS-1:0]       dir_force_in_out,
  input wire logic [PINS-1:0]       port_dir_eff_out,
  input wire logic                  irq_out,
  input wire logic                  wake_out,
  input wire logic                  pending_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!resetn_in);
  logic ctl_wr, ctl_rd, en_rd, mode_r;
  assign ctl_wr = bus_in.wr && bus_in.addr == kbu_pkg::KEY_STATUS_CONTROL_OFFS;
  assign ctl_rd = bus_in.rd && bus_in.addr == kbu_pkg::KEY_STATUS_CONTROL_OFFS;
  assign en_rd  = bus_in.rd && bus_in.addr == kbu_pkg::KEY_PIN_ENABLE_BITS_OFFS;
  // Shadow of the mode bit, seen only through bus writes
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) mode_r <= 1'b0;
    else if (ctl_wr) mode_r <= bus_in.wdata[0];
  end
  sequence s_low_level;
    mode_r && |(~key_inputs_in & pullup_en_out);
  endsequence
  sequence s_edge_fetch;
    sys_in.vector_fetch && !mode_r;
  endsequence
  a_irq_needs_pend: assert property (irq_out |-> pending_out)
    else $error("irq without pending request");
  a_wake_needs_pend: assert property (wake_out |-> pending_out)
    else $error("wake without pending request");
  a_force_pullup: assert property (pullup_en_out == dir_force_in_out)
    else $error("pull-up and input force differ");
  a_dir_override: assert property ($past(resetn_in) |->
    port_dir_eff_out == ($past(port_dir_in) & ~pullup_en_out))
    else $error("direction override wrong");
  a_rdata_idle: assert property (!$past(bus_in.rd) |-> rdata_out == 8'h00)
    else $error("read data outside read slot");
  a_ctl_readback: assert property ($past(ctl_rd) |->
    !rdata_out[2] && rdata_out[3] == $past(pending_out))
    else $error("status read wrong");
  a_enable_readback: assert property ($past(en_rd) |-> rdata_out == pullup_en_out)
    else $error("enable read wrong");
  a_fetch_clears: assert property (s_edge_fetch |=> !pending_out)
    else $error("fetch did not clear");
  a_level_holds: assert property (s_low_level [*8] |-> pending_out)
    else $error("level request dropped");
  a_break_protect: assert property (sys_in.break_state && !sys_in.break_clear_enable
    && pending_out && ctl_wr && bus_in.wdata[2] && !sys_in.vector_fetch |=> pending_out)
    else $error("ack acted in break");
endmodule : kbu_keyboard_unit_sva

bind kbu_keyboard_unit kbu_keyboard_unit_sva #(.PINS(PINS)) u_sva (
  .clock_in(clock_in), .resetn_in(resetn_in), .bus_in(bus_in), .rdata_out(rdata_out),
  .sys_in(sys_in), .key_inputs_in(key_inputs_in), .port_dir_in(port_dir_in),
  .pullup_en_out(pullup_en_out), .dir_force_in_out(dir_force_in_out),
  .port_dir_eff_out(port_dir_eff_out), .irq_out(irq_out), .wake_out(wake_out),
  .pending_out(pending_out));

`default_nettype wire

// ### test/tb_kbu_keyboard_unit.sv
`timescale 1ns/1ps
`default_nettype none

module tb_kbu_keyboard_unit;
  logic                  clock_in  = 1'b0;
  logic                  resetn_in = 1'b0;
  kbu_pkg::kbu_bus_req_t bus       = '0;
  kbu_pkg::kbu_sys_t     sys       = '0;
  logic [7:0]            press     = 8'h00;
  logic [7:0]            dir       = 8'h00;
  logic [7:0]            pins, rdata, pull, dir_eff, dir_force;
  logic                  irq, wake, pend;
  int                    n_fail      = 0;
  int                    check_count = 0;

  kbu_keyboard_unit dut (.clock_in(clock_in), .resetn_in(resetn_in), .bus_in(bus),
    .rdata_out(rdata), .sys_in(sys), .key_inputs_in(pins), .port_dir_in(dir),
    .pullup_en_out(pull), .dir_force_in_out(dir_force), .port_dir_eff_out(dir_eff),
    .irq_out(irq), .wake_out(wake), .pending_out(pend));
  kbu_key_model keys (.clock_in(clock_in), .press_in(press), .pullup_in(pull), .pins_out(pins));

  initial begin
    forever #2 clock_in = ~clock_in;
  end

  // ==========================================================================
  // Access tasks
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_in) bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clock_in) bus <= '0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock_in) bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clock_in) bus <= '0;
    #1 chk(rdata, exp);
  endtask : rd
  // Eight cycles cover the four-clock pin latency
  task automatic key(input logic [7:0] p);
    @(posedge clock_in) press <= p;
    repeat (8) @(posedge clock_in);
  endtask : key
  task automatic st(input logic [2:0] e);
    #1 chk({5'h00, pend, irq, wake}, {5'h00, e});
  endtask : st
  task automatic fetch;
    @(posedge clock_in) sys.vector_fetch <= 1'b1;
    @(posedge clock_in) sys.vector_fetch <= 1'b0;
  endtask : fetch
  task automatic give_verdict;
    if (n_fail == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : give_verdict

  // ==========================================================================
  // Tests
  initial begin
    repeat (8) @(posedge clock_in);
    resetn_in <= 1'b1;
    rd(8'h1A, 8'h00);
    rd(8'h1B, 8'h00);
    rd(8'h10, 8'h00);
    wr(8'h1A, 8'h02);
    wr(8'h1B, 8'h03);
    wr(8'h1A, 8'h06);
    wr(8'h1A, 8'h00);
    dir <= 8'hFF;
    key(8'h00);
    chk(pull, 8'h03);
    chk(dir_eff, 8'hFC);
    chk(dir_force, 8'h03);
    key(8'h80);
    st(3'b000);
    key(8'h01);
    st(3'b110);
    rd(8'h1A, 8'h08);
    wr(8'h1A, 8'h04);
    st(3'b000);
    key(8'h03);
    st(3'b000);
    key(8'h00);
    key(8'h02);
    st(3'b110);
    fetch();
    st(3'b000);
    key(8'h00);
    wr(8'h1A, 8'h02);
    key(8'h01);
    st(3'b100);
    sys.wait_mode <= 1'b1;
    wr(8'h1A, 8'h00);
    key(8'h01);
    st(3'b111);
    sys <= '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
    key(8'h01);
    st(3'b111);
    sys <= '0;
    fetch();
    key(8'h00);
    wr(8'h1A, 8'h01);
    key(8'h01);
    st(3'b110);
    wr(8'h1A, 8'h05);
    key(8'h01);
    st(3'b110);
    key(8'h00);
    st(3'b000);
    key(8'h02);
    key(8'h00);
    st(3'b110);
    sys.break_state <= 1'b1;
    wr(8'h1A, 8'h05);
    st(3'b110);
    sys.break_clear_enable <= 1'b1;
    wr(8'h1A, 8'h05);
    st(3'b000);
    sys <= '0;
    key(8'h00);
    st(3'b000);
    key(8'h01);
    resetn_in <= 1'b0;
    repeat (3) @(posedge clock_in);
    resetn_in <= 1'b1;
    key(8'h01);
    st(3'b000);
    rd(8'h1A, 8'h00);
    give_verdict();
  end

  // Tests take about 220 cycles; this leaves ample margin
  initial begin
    #40000;
    n_fail++;
    give_verdict();
  end
endmodule : tb_kbu_keyboard_unit

`default_nettype wire
